/* verilog/iop_pkg.sv */
// Package for the stand-alone I/O station parallel port logic.
// Assumes a single 20 MHz clock and an asynchronous active-low reset.
package iop_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PORT_W      = 32;
  localparam int BLOCK_W     = 64;
  localparam int BLK_SEL_W   = 6;
  localparam int POL_W       = 8;
  localparam int POL_GROUP   = 4;
  localparam int STRAP_W     = 3;
  localparam int HALF_W      = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ         = 20;
  localparam int STROBE_NS       = 500;
  localparam int STROBE_CYC      = (STROBE_NS * CLK_MHZ) / 1000;
  localparam int FRESH_US        = 1000;
  localparam int FRESH_CYC       = FRESH_US * CLK_MHZ;
  localparam int CNT_W           = 16;

  // ****************************************************************
  // Direction strap decode: one direction bit per byte of the port
  // ****************************************************************
  localparam logic [3:0] DIR_TABLE [8] = '{
    4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8
  };

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic                 valid;
    logic [BLOCK_W-1:0]   data;
  } iop_block_s;

  typedef struct packed {
    logic [STRAP_W-1:0]   dir_strap;
    logic                 swap_n;
    logic [POL_W-1:0]     polarity;
  } iop_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PULSE = 2'b01,
    ST_HOLD  = 2'b11
  } iop_strobe_e;

endpackage

/* verilog/iop_strobe.sv */
// Fixed-length pulse generator for the update and capture strobes.
// Assumes a trigger pulse synchronous to CLK_I; retriggers restart it.
`timescale 1ns/1ps
module iop_strobe (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // Trigger and strobe
  input  wire logic trig_i,
  output logic      strobe_o
);

  iop_pkg::iop_strobe_e          state_reg;
  logic [iop_pkg::CNT_W-1:0]     cnt_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= iop_pkg::ST_IDLE;
      cnt_reg   <= '0;
    end else if (ce_i) begin
      case (state_reg)
        iop_pkg::ST_IDLE: begin
          if (trig_i) begin
            state_reg <= iop_pkg::ST_PULSE;
            cnt_reg   <= iop_pkg::CNT_W'(iop_pkg::STROBE_CYC - 1);
          end
        end
        iop_pkg::ST_PULSE: begin
          if (trig_i) begin
            cnt_reg <= iop_pkg::CNT_W'(iop_pkg::STROBE_CYC - 1);
          end else if (cnt_reg == '0) begin
            state_reg <= iop_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= iop_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign strobe_o = (state_reg == iop_pkg::ST_PULSE);

endmodule // iop_strobe

/* verilog/iop_dir.sv */
// Per-pin direction decode from the strap inputs and the swap input.
// Assumes straps are static or change only while the port is idle.
`timescale 1ns/1ps
module iop_dir (
  // Configuration
  input  wire logic [iop_pkg::STRAP_W-1:0] dir_strap_i,
  input  wire logic                        swap_n_i,
  // Direction per pin, one is output
  output logic [iop_pkg::PORT_W-1:0]       dir_out_o
);

  logic [3:0] byte_dir;

  always_comb begin
    byte_dir = iop_pkg::DIR_TABLE[dir_strap_i];
  end

  genvar g;
  generate
    for (g = 0; g < iop_pkg::PORT_W; g++) begin : g_dir
      // Swap low turns every direction round
      assign dir_out_o[g] = byte_dir[g / 8] ^ ~swap_n_i;
    end
  endgenerate

endmodule // iop_dir

/* verilog/iop_port.sv */
// Parallel I/O port of the stand-alone I/O station.
// Assumes the network core delivers received blocks and ping events as
// one-cycle pulses on CLK_I; mode and frame option are board straps.
//
// Behaviour
// - Ping output goes high on received ping
// - Fresh high while outputs updated within timeout
// - Fresh output low during reset
// - Upper clear zeroes output latch bits 16-31
// - Lower clear zeroes output latch bits 0-15
// - Half select high picks lower block bits
// - Polarity high inverts pin level
// - Direction straps set each pin direction
// - Swap input low inverts every direction
// - Thirty-two bit bidirectional general purpose port
// - Stale output is complement, high in reset
// - Capture strobe pulses on input sampling
`timescale 1ns/1ps
module iop_port (
  // Clock and reset
  input  wire logic                          CLK_I,
  input  wire logic                          NRST_I,
  input  wire logic                          CE_I,
  // Straps and mode
  input  wire logic                          MODE_IO_I,
  input  wire logic                          LONG_FRAME_SEL_N_I,
  input  wire logic                          HALF_SELECT_N_I,
  input  wire logic [iop_pkg::POL_W-1:0]     POLARITY_IN_I,
  input  wire logic [iop_pkg::STRAP_W-1:0]   DIRECTION_STRAP_I,
  input  wire logic                          DIRECTION_SWAP_N_I,
  input  wire logic                          UPPER_CLEAR_N_I,
  input  wire logic                          LOWER_CLEAR_N_I,
  input  wire logic [iop_pkg::BLK_SEL_W-1:0] BLOCK_SELECT_N_I,
  // Network core side
  input  wire logic                          PING_RX_I,
  input  wire logic                          BLOCK_VALID_I,
  input  wire logic [iop_pkg::BLK_SEL_W-1:0] BLOCK_NUM_I,
  input  wire logic [iop_pkg::BLOCK_W-1:0]   BLOCK_DATA_I,
  input  wire logic                          SAMPLE_I,
  output logic [iop_pkg::PORT_W-1:0]         CAPTURE_DATA_O,
  output logic                               IO_MODE_O,
  output logic                               LONG_FRAME_O,
  output logic [iop_pkg::BLK_SEL_W-1:0]      BLOCK_SELECT_O,
  // Port pins
  input  wire logic [iop_pkg::PORT_W-1:0]    PORT_PINS_I,
  output logic [iop_pkg::PORT_W-1:0]         PORT_PINS_O,
  output logic [iop_pkg::PORT_W-1:0]         PORT_PINS_OE_O,
  // Status
  output logic                               PING_O,
  output logic                               DATA_FRESH_OUT_O,
  output logic                               DATA_STALE_OUT_O,
  output logic                               UPDATE_STROBE_O,
  output logic                               CAPTURE_STROBE_O
);

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic [iop_pkg::PORT_W-1:0]    dir_out;
  logic [iop_pkg::PORT_W-1:0]    latch_reg;
  logic [iop_pkg::PORT_W-1:0]    latch_next;
  logic [iop_pkg::PORT_W-1:0]    cap_reg;
  logic [iop_pkg::PORT_W-1:0]    pol_bits;
  logic [iop_pkg::PORT_W-1:0]    pin_logic;
  logic [iop_pkg::BLK_SEL_W-1:0] blk_sel;
  logic [iop_pkg::CNT_W+4:0]     fresh_cnt_reg;
  logic                          update;
  logic                          ping_reg;
  logic                          fresh_reg;
  iop_pkg::iop_cfg_s             cfg;
  iop_pkg::iop_block_s           blk;

  assign cfg = '{dir_strap: DIRECTION_STRAP_I,
                 swap_n:    DIRECTION_SWAP_N_I,
                 polarity:  POLARITY_IN_I};
  assign blk = '{valid: BLOCK_VALID_I, data: BLOCK_DATA_I};

  // ****************************************************************
  // Straps passed to the network core
  // ****************************************************************
  // Mode and frame option are only reported; the core acts on them
  assign IO_MODE_O      = MODE_IO_I;
  assign LONG_FRAME_O   = ~LONG_FRAME_SEL_N_I;
  assign blk_sel        = ~BLOCK_SELECT_N_I;
  assign BLOCK_SELECT_O = blk_sel;

  // ****************************************************************
  // Direction
  // ****************************************************************
  iop_dir u_dir (
    .dir_strap_i (cfg.dir_strap),
    .swap_n_i    (cfg.swap_n),
    .dir_out_o   (dir_out)
  );

  // ****************************************************************
  // Output latch
  // ****************************************************************
  assign update = CE_I && blk.valid && (BLOCK_NUM_I == blk_sel);

  always_comb begin
    latch_next = latch_reg;
    if (update) begin
      latch_next = HALF_SELECT_N_I ? blk.data[iop_pkg::PORT_W-1:0]
                                   : blk.data[iop_pkg::BLOCK_W-1:iop_pkg::PORT_W];
    end
    // Clears are level inputs and override any update in the same cycle
    if (!UPPER_CLEAR_N_I) begin
      latch_next[iop_pkg::PORT_W-1:iop_pkg::HALF_W] = '0;
    end
    if (!LOWER_CLEAR_N_I) begin
      latch_next[iop_pkg::HALF_W-1:0] = '0;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      latch_reg <= '0;
    end else if (CE_I) begin
      latch_reg <= latch_next;
    end
  end

  // ****************************************************************
  // Pin polarity and drive
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < iop_pkg::PORT_W; g++) begin : g_pin
      assign pol_bits[g] = cfg.polarity[g / iop_pkg::POL_GROUP];
      assign PORT_PINS_O[g] = latch_reg[g] ^ pol_bits[g];
      assign pin_logic[g]   = PORT_PINS_I[g] ^ pol_bits[g];
    end
  endgenerate

  // Input pins are never driven
  assign PORT_PINS_OE_O = dir_out;

  // ****************************************************************
  // Input capture
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cap_reg <= '0;
    end else if (CE_I && SAMPLE_I) begin
      cap_reg <= pin_logic & ~dir_out;
    end
  end

  assign CAPTURE_DATA_O = cap_reg;

  // ****************************************************************
  // Strobes
  // ****************************************************************
  iop_strobe u_upd_stb (
    .clk_i    (CLK_I),
    .nrst_i   (NRST_I),
    .ce_i     (CE_I),
    .trig_i   (update),
    .strobe_o (UPDATE_STROBE_O)
  );

  iop_strobe u_cap_stb (
    .clk_i    (CLK_I),
    .nrst_i   (NRST_I),
    .ce_i     (CE_I),
    .trig_i   (SAMPLE_I),
    .strobe_o (CAPTURE_STROBE_O)
  );

  // ****************************************************************
  // Ping indication
  // ****************************************************************
  // A level that follows each received ping; reset forces it low
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ping_reg <= 1'b0;
    end else if (CE_I) begin
      ping_reg <= PING_RX_I;
    end
  end

  assign PING_O = ping_reg;

  // ****************************************************************
  // Data freshness
  // ****************************************************************
  // Timeout restarts on each update; fresh drops when it runs out
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      fresh_cnt_reg <= '0;
      fresh_reg     <= 1'b0;
    end else if (CE_I) begin
      if (update) begin
        fresh_cnt_reg <= ($bits(fresh_cnt_reg))'(iop_pkg::FRESH_CYC - 1);
        fresh_reg     <= 1'b1;
      end else if (fresh_cnt_reg != '0) begin
        fresh_cnt_reg <= fresh_cnt_reg - 1'b1;
      end else begin
        fresh_reg <= 1'b0;
      end
    end
  end

  assign DATA_FRESH_OUT_O = fresh_reg;
  assign DATA_STALE_OUT_O = ~fresh_reg;

endmodule // iop_port

/* bench/iop_port_assertions.sv */
// Checker for iop_port: pins, strobes, freshness, ping, reset levels.
// Sees only the top module ports; bound below by name.
`timescale 1ns/1ps
module iop_port_chk (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        NRST_I,
  input wire logic        CE_I,
  // Inputs
  input wire logic        HALF_SELECT_N_I,
  input wire logic [7:0]  POLARITY_IN_I,
  input wire logic [2:0]  DIRECTION_STRAP_I,
  input wire logic        DIRECTION_SWAP_N_I,
  input wire logic        UPPER_CLEAR_N_I,
  input wire logic        LOWER_CLEAR_N_I,
  input wire logic [5:0]  BLOCK_SELECT_N_I,
  input wire logic        PING_RX_I,
  input wire logic        BLOCK_VALID_I,
  input wire logic [5:0]  BLOCK_NUM_I,
  input wire logic [63:0] BLOCK_DATA_I,
  input wire logic        SAMPLE_I,
  // Outputs
  input wire logic [31:0] PORT_PINS_O,
  input wire logic [31:0] PORT_PINS_OE_O,
  input wire logic        PING_O,
  input wire logic        DATA_FRESH_OUT_O,
  input wire logic        DATA_STALE_OUT_O,
  input wire logic        UPDATE_STROBE_O,
  input wire logic        CAPTURE_STROBE_O
);
  logic [31:0] polx, dirx, lat_exp;
  // Latch seen through the polarity, only where the pin is driven
  wire  [31:0] lat_now = (PORT_PINS_O ^ polx) & PORT_PINS_OE_O;
  // Any accepted block restarts strobe and freshness, even under a clear
  wire         take = CE_I && BLOCK_VALID_I && BLOCK_NUM_I == ~BLOCK_SELECT_N_I;
  wire         upd  = take && UPPER_CLEAR_N_I && LOWER_CLEAR_N_I;
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      polx[i] = POLARITY_IN_I[i/4];
      dirx[i] = iop_pkg::DIR_TABLE[DIRECTION_STRAP_I][i/8] ^ !DIRECTION_SWAP_N_I;
    end
  end
  always_ff @(posedge CLK_I) lat_exp <= HALF_SELECT_N_I ? BLOCK_DATA_I[31:0]
                                                        : BLOCK_DATA_I[63:32];
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  AST_PING: assert property (CE_I && PING_RX_I |=> PING_O) else $error("ping");
  // Reset must have been seen at two edges, so the power-up edge is settled
  AST_RST: assert property (disable iff (1'b0) (!NRST_I ##1 !NRST_I) |->
    !PING_O && !DATA_FRESH_OUT_O && DATA_STALE_OUT_O && !UPDATE_STROBE_O && !CAPTURE_STROBE_O)
    else $error("reset");
  AST_STALE: assert property (DATA_STALE_OUT_O != DATA_FRESH_OUT_O) else $error("stale");
  AST_FRESH: assert property (take |=> DATA_FRESH_OUT_O) else $error("fresh");
  AST_UPD: assert property (take |=> UPDATE_STROBE_O [*8]) else $error("strobe");
  AST_IDLE: assert property ($rose(UPDATE_STROBE_O) |-> $past(take)) else $error("idle");
  AST_PINS: assert property (upd |=> lat_now == (lat_exp & PORT_PINS_OE_O))
    else $error("pins");
  AST_UCLR: assert property (CE_I && !UPPER_CLEAR_N_I |=> lat_now[31:16] == 16'h0000)
    else $error("upper");
  AST_LCLR: assert property (CE_I && !LOWER_CLEAR_N_I |=> lat_now[15:0] == 16'h0000)
    else $error("lower");
  AST_DIR: assert property (PORT_PINS_OE_O == dirx) else $error("dir");
  AST_CAP: assert property (CE_I && SAMPLE_I |=> CAPTURE_STROBE_O [*8]) else $error("cap");
  COV_UPD: cover property (upd);
  COV_CLR: cover property (!UPPER_CLEAR_N_I);
  COV_CAP: cover property (SAMPLE_I);
endmodule // iop_port_chk

bind iop_port iop_port_chk i_iop_port_chk (.*);

/* bench/iop_equip.sv */
// External equipment on the port pins.
// Assumes the bench seeds $urandom before the first clock edge.
`timescale 1ns/1ps
module iop_equip (
  // Clock
  input  wire logic        clk_i,
  // Device side of the pins
  input  wire logic [31:0] pins_o_i,
  input  wire logic [31:0] oe_i,
  output logic      [31:0] wire_o
);
  logic [31:0] drv_reg = 32'h0000_0000;
  // Pins we drive change every clock, so a stale capture cannot pass
  always @(posedge clk_i) drv_reg <= $urandom;
  assign wire_o = (pins_o_i & oe_i) | (drv_reg & ~oe_i);
endmodule // iop_equip

/* bench/iop_port_tb.sv */
// Self-checking bench for iop_port with the equipment model.
// Assumes package, design and checker are compiled before it.
`timescale 1ns/1ps
module iop_port_tb;
  logic        clk = 0, nrst = 0, ping = 1, val = 0, smp = 0, ce = 1, lf = 1;
  logic        hs = 1, uc = 1, lc = 1, sw = 1, pg, fr, sl, us, cs, iom, lfo;
  logic [7:0]  pol = 8'h00;
  logic [2:0]  st = 3'h4;
  logic [5:0]  bs = 6'h3F, bn = 6'h00, bso;
  logic [63:0] bd = 64'h0;
  logic [31:0] pin_i, pin_o, oe, cap, e, lat = 32'h0;
  int          failures = 0, n_compared = 0, k;
  always #25 clk = ~clk;
  iop_port i_iop_port (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .MODE_IO_I(1'b1), .LONG_FRAME_SEL_N_I(lf),
    .HALF_SELECT_N_I(hs), .POLARITY_IN_I(pol), .DIRECTION_STRAP_I(st),
    .DIRECTION_SWAP_N_I(sw), .UPPER_CLEAR_N_I(uc), .LOWER_CLEAR_N_I(lc),
    .BLOCK_SELECT_N_I(bs), .PING_RX_I(ping), .BLOCK_VALID_I(val), .BLOCK_NUM_I(bn),
    .BLOCK_DATA_I(bd), .SAMPLE_I(smp), .CAPTURE_DATA_O(cap), .IO_MODE_O(iom),
    .LONG_FRAME_O(lfo), .BLOCK_SELECT_O(bso), .PORT_PINS_I(pin_i), .PORT_PINS_O(pin_o),
    .PORT_PINS_OE_O(oe), .PING_O(pg), .DATA_FRESH_OUT_O(fr), .DATA_STALE_OUT_O(sl),
    .UPDATE_STROBE_O(us), .CAPTURE_STROBE_O(cs));
  iop_equip i_iop_equip (.clk_i(clk), .pins_o_i(pin_o), .oe_i(oe), .wire_o(pin_i));
  function automatic logic [31:0] polx(logic [7:0] p);
    for (int i = 0; i < 32; i++) polx[i] = p[i/4];
  endfunction
  function automatic logic [31:0] dirx(logic [2:0] s, logic w);
    for (int i = 0; i < 32; i++) dirx[i] = iop_pkg::DIR_TABLE[s][i/8] ^ !w;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic test_done;
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Valid idles one cycle between calls; returns one negedge after the take
  task automatic upd(logic good);
    int r;
    @(negedge clk);
    r = $urandom;
    bd = {$urandom, $urandom};
    hs = r[0];
    ping = r[1];
    pol = r[15:8];
    bs = r[21:16];
    bn = good ? ~bs : ~bs ^ 6'h01;
    val = 1;
    @(negedge clk) val = 0;
    if (good) lat = hs ? bd[31:0] : bd[63:32];
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    k = $urandom(5545);
    repeat (10) @(negedge clk);
    chk(pg, 0, "ping rst");
    chk(fr, 0, "fresh rst");
    chk(sl, 1, "stale rst");
    nrst = 1;
    for (k = 0; k < 16; k++) begin
      st = k[2:0];
      sw = k[3];
      lf = k[0];
      @(negedge clk);
      chk(oe, dirx(st, sw), "dir");
      chk(lfo, !lf, "frame");
      chk(iom, 1, "mode");
    end
    st = 3'h4;
    sw = 1;
    lf = 1;
    for (k = 0; k < 40; k++) begin
      upd(k % 4 != 0);
      chk(pin_o, lat ^ polx(pol), "pins");
      chk(pg, ping, "ping");
      chk(bso, 6'(~bs), "block sel");
    end
    upd(1);
    for (k = 0; us === 1'b1 && k < 20; k++) @(negedge clk);
    chk(k, iop_pkg::STROBE_CYC, "strobe");
    for (k = 0; k < 2; k++) begin
      uc = k[0];
      lc = !k[0];
      upd(1);
      if (k == 0) lat[31:16] = 16'h0000;
      else lat[15:0] = 16'h0000;
      chk(pin_o, lat ^ polx(pol), "clear");
    end
    uc = 1;
    lc = 1;
    st = 3'h2;
    @(negedge clk);
    for (k = 0; k < 8; k++) begin
      smp = 1;
      e = (pin_i ^ polx(pol)) & ~oe;
      @(negedge clk) smp = 0;
      chk(cap, e, "capture");
      chk(cs, 1, "cap strobe");
      @(negedge clk);
    end
    // Clock enable low: a matching block must leave the latch alone
    ce = 0;
    e = lat;
    upd(1);
    lat = e;
    chk(pin_o, lat ^ polx(pol), "frozen");
    ce = 1;
    upd(1);
    repeat (iop_pkg::FRESH_CYC - 1) @(negedge clk);
    chk(fr, 1, "fresh");
    @(negedge clk);
    chk(fr, 0, "fresh end");
    chk(sl, 1, "stale");
    upd(1);
    ping = 1;
    nrst = 0;
    @(negedge clk);
    chk(pg, 0, "ping rst2");
    chk(fr, 0, "fresh rst2");
    chk(us, 0, "strobe rst2");
    repeat (9) @(negedge clk);
    nrst = 1;
    @(negedge clk);
    chk(pg, 1, "ping again");
    chk(sl, 1, "stale again");
    test_done;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule // iop_port_tb
